// >>> rtl/tsq_top.sv
// What this block does
// [RULE1] Primary branch out of last term triggers
// [RULE2] Primary branch goes to next term only
// [RULE3] Secondary branch restarts at term one
// [RULE4] At most four sequence terms
// [RULE5] Insert at n shifts terms n upward
// [RULE6] Insert one past last appends term
// [RULE7] Delete renumbers later terms downward
// [RULE8] After trigger, term reads last plus one
// [RULE9] Halted trace reports term before halt
// [RULE10] Fast changing term reports unknown marker
// [RULE11] Report occurrences left in current term
// [RULE12] Fast changing count reports unknown marker
// [RULE13] 512 state memory, captured count reported
// [RULE14] Trigger placed at start by default
// [RULE15] Start placement fills memory after trigger
// [RULE16] Centre and end placements selectable
// [RULE17] Placement by count before or after
// [RULE18] Placement within one state of request
// [RULE19] Branch states always stored, plus qualifier
// [RULE20] Primary branch after occurrence count matches
// [RULE21] New term defaults to match any
// [RULE22] Entries indexed relative to trigger entry
module tsq_top import tsq_pkg::*; (
    input wire logic mclk,
    input wire logic srst,
    input wire tsq_apb_req_t apb_req,
    output tsq_apb_rsp_t apb_rsp,
    input wire tsq_sample_t smp,
    output logic triggered,
    output logic trace_done
);
    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        tsq_apb_rsp_t rsp;                 // Bus answer
        tsq_place_t mode;                  // Placement mode
        logic after;                       // Count is after trigger
        logic [AW-1:0] tpos;               // Placement count
        logic [TW-1:0] nterms;             // Defined terms
        tsq_term_t [NTERM-1:0] terms;      // Term settings
        logic [TW-1:0] term;               // Active term, from one
        logic [OCW-1:0] occ_left;          // Occurrences left
        tsq_phase_t phase;                 // Trace phase
        logic trig;                        // Trigger seen
        logic halted;                      // Stopped by software
        logic done;                        // Trace finished, drives output
        logic chg_term;                    // Term moved last cycle
        logic chg_occ;                     // Count moved last cycle
        logic [AW-1:0] wptr;               // Next write slot
        logic [AW:0] pre_cnt;              // States before trigger
        logic [AW:0] post_cnt;             // States after trigger
        logic [AW-1:0] pre_keep;           // Wanted states before
        logic [AW-1:0] trig_addr;          // Slot of trigger state
        logic [AW-1:0] rdidx;              // Read index, signed
        logic [DEPTH-1:0][DW-1:0] mem;     // Trace memory
    } tsq_state_t;

    tsq_state_t q_reg;    // Registered state
    tsq_state_t s_next;   // Next state

    // Zero count reads as one
    function automatic logic [OCW-1:0] occ_load(input logic [OCW-1:0] v);
        return (v == '0) ? OCC_ONE : v;
    endfunction

    // Slot of a one-based term number
    function automatic logic [1:0] slot(input logic [TW-1:0] t);
        return 2'(t - TERM_ONE);
    endfunction

    // States kept before the trigger
    function automatic logic [AW-1:0] pre_from(input tsq_place_t m, input logic a, input logic [AW-1:0] n);
        unique case (m)
            PLACE_START: return '0;
            PLACE_CENTRE: return PRE_CENTRE;
            PLACE_END: return PRE_END;
            PLACE_COUNT: return a ? AW'(PRE_END - n) : n;
        endcase
    endfunction

    // ****************************************
    // Next state
    // ****************************************
    logic access;                 // Access phase of a transfer
    logic commit;                 // Write takes effect now
    logic [7:0] addr;             // Byte address
    logic [31:0] wd;              // Write data
    logic edit_ok;                // Terms may be edited
    logic [TW-1:0] pos;           // Command position
    logic hit;                    // Primary condition met
    logic store;                  // State goes to memory
    logic [AW:0] kept;            // Pre-trigger states kept
    logic [AW:0] captured;        // States captured
    logic [AW-1:0] post_target;   // States wanted after trigger

    // Whole block next state
    always_comb begin
        s_next = q_reg;
        access = apb_req.psel & apb_req.penable;
        commit = access & q_reg.rsp.pready & apb_req.pwrite & ~q_reg.rsp.pslverr;
        addr = apb_req.paddr;
        wd = apb_req.pwdata;
        pos = wd[CMD_POS +: TW];
        edit_ok = (q_reg.phase != PH_ARMED) && (q_reg.phase != PH_POST);
        hit = 1'b0;
        store = 1'b0;
        post_target = AW'(PRE_END - q_reg.pre_keep);
        kept = (q_reg.pre_cnt > {1'b0, q_reg.pre_keep}) ? {1'b0, q_reg.pre_keep} : q_reg.pre_cnt;
        captured = q_reg.trig ? (AW+1)'(kept + q_reg.post_cnt + 1'b1) : q_reg.pre_cnt;  // see [RULE13]

        // Sequencer runs on each valid sample while armed
        if (q_reg.phase == PH_ARMED && smp.valid) begin
            hit = smp.hit[slot(q_reg.term)] | q_reg.terms[slot(q_reg.term)].any;  // see [RULE21]
            if (hit) begin
                store = 1'b1;  // see [RULE19]
                if (q_reg.occ_left <= OCC_ONE) begin
                    // Primary branch after enough matches, see [RULE20]
                    if (q_reg.term == q_reg.nterms) begin
                        s_next.phase = PH_POST;  // see [RULE1]
                        s_next.trig = 1'b1;
                        s_next.term = q_reg.nterms + TERM_ONE;  // see [RULE8]
                        s_next.trig_addr = q_reg.wptr;
                        s_next.occ_left = '0;
                        if (post_target == '0) begin
                            s_next.phase = PH_DONE;  // see [RULE15]
                        end
                    end else begin
                        s_next.term = q_reg.term + TERM_ONE;  // see [RULE2]
                        s_next.occ_left = occ_load(q_reg.terms[slot(q_reg.term + TERM_ONE)].occ);
                    end
                end else begin
                    s_next.occ_left = q_reg.occ_left - OCC_ONE;  // see [RULE11]
                end
            end else if (smp.restart) begin
                // Global restart
                store = 1'b1;  // see [RULE19]
                s_next.term = TERM_ONE;  // see [RULE3]
                s_next.occ_left = occ_load(q_reg.terms[0].occ);
            end
            if (smp.store) begin
                store = 1'b1;
            end
            if (store && s_next.phase == PH_ARMED && q_reg.pre_cnt <= (AW+1)'(PRE_END)) begin
                s_next.pre_cnt = q_reg.pre_cnt + 1'b1;
            end
        end else if (q_reg.phase == PH_POST && smp.valid && smp.store) begin
            // Fill after trigger, then stop
            store = 1'b1;
            s_next.post_cnt = q_reg.post_cnt + 1'b1;
            if (s_next.post_cnt == {1'b0, post_target}) begin
                s_next.phase = PH_DONE;  // see [RULE15] [RULE18]
            end
        end

        // Write the sample
        if (store) begin
            s_next.mem[q_reg.wptr] = smp.data;
            s_next.wptr = q_reg.wptr + 1'b1;
        end

        // Register writes
        if (commit) begin
            unique case (addr)
                ADDR_CTRL: begin
                    s_next.mode = tsq_place_t'(wd[CTRL_MODE +: 2]);  // see [RULE16] [RULE17]
                    s_next.after = wd[CTRL_AFTER];
                    if (wd[CTRL_START]) begin
                        s_next.phase = PH_ARMED;
                        s_next.trig = 1'b0;
                        s_next.halted = 1'b0;
                        s_next.term = TERM_ONE;
                        s_next.occ_left = occ_load(q_reg.terms[0].occ);
                        s_next.wptr = '0;
                        s_next.pre_cnt = '0;
                        s_next.post_cnt = '0;
                        s_next.pre_keep = pre_from(tsq_place_t'(wd[CTRL_MODE +: 2]), wd[CTRL_AFTER], q_reg.tpos);
                    end else if (wd[CTRL_HALT] && !edit_ok) begin
                        s_next.phase = PH_DONE;  // see [RULE9]
                        s_next.halted = 1'b1;
                        s_next.term = q_reg.term;
                        s_next.occ_left = q_reg.occ_left;
                    end
                end
                ADDR_TPOS: s_next.tpos = wd[AW-1:0];  // see [RULE17]
                ADDR_RDIDX: s_next.rdidx = wd[AW-1:0];
                ADDR_SEQCMD: begin
                    unique case (tsq_cmd_t'(wd[1:0]))
                        CMD_INSERT: begin
                            for (int i = NTERM - 1; i >= 0; i--) begin
                                if (i + 1 > int'(pos)) begin
                                    // Index wraps so no slot below zero is named
                                    s_next.terms[i] = q_reg.terms[(i + NTERM - 1) % NTERM];  // see [RULE5]
                                end
                                if (i + 1 == int'(pos)) begin
                                    s_next.terms[i] = TERM_DEFAULT;  // see [RULE6] [RULE21]
                                end
                            end
                            s_next.nterms = q_reg.nterms + TERM_ONE;
                        end
                        CMD_DELETE: begin
                            for (int i = 0; i < NTERM; i++) begin
                                if (i + 1 >= int'(pos)) begin
                                    s_next.terms[i] = (i < NTERM - 1) ? q_reg.terms[(i + 1) % NTERM] : TERM_DEFAULT;  // see [RULE7]
                                end
                            end
                            s_next.nterms = q_reg.nterms - TERM_ONE;
                        end
                        CMD_RESET: begin
                            s_next.nterms = TERM_ONE;
                            s_next.terms = {NTERM{TERM_DEFAULT}};
                        end
                        CMD_NONE: begin
                        end
                    endcase
                end
                default: begin
                    // Term settings
                    if (addr >= ADDR_TERM0 && addr <= ADDR_TERM3) begin
                        s_next.terms[addr[3:2]] = '{any: wd[TERM_ANY], occ: wd[OCW-1:0]};
                    end
                end
            endcase
        end

        // Bus answer, one wait state
        s_next.rsp = '0;
        if (access && !q_reg.rsp.pready) begin
            s_next.rsp.pready = 1'b1;
            unique case (addr)
                ADDR_CTRL: s_next.rsp.prdata = 32'({q_reg.after, q_reg.mode, 2'b00});
                ADDR_TPOS: s_next.rsp.prdata = 32'(q_reg.tpos);
                ADDR_SEQCMD: begin
                    s_next.rsp.prdata = '0;
                    if (apb_req.pwrite) begin
                        // Refuse edits while running or out of range, see [RULE4]
                        unique case (tsq_cmd_t'(wd[1:0]))
                            CMD_INSERT: s_next.rsp.pslverr = !edit_ok || q_reg.nterms == TW'(NTERM)
                                || pos == '0 || pos > q_reg.nterms + TERM_ONE;
                            CMD_DELETE: s_next.rsp.pslverr = !edit_ok || q_reg.nterms == TERM_ONE
                                || pos == '0 || pos > q_reg.nterms;
                            CMD_RESET: s_next.rsp.pslverr = !edit_ok;
                            CMD_NONE: s_next.rsp.pslverr = 1'b0;
                        endcase
                    end
                end
                ADDR_STATUS: begin
                    s_next.rsp.prdata[TW-1:0] = q_reg.chg_term ? '0 : q_reg.term;  // see [RULE9] [RULE10]
                    s_next.rsp.prdata[ST_UNK_TERM] = q_reg.chg_term;  // see [RULE10]
                    s_next.rsp.prdata[ST_UNK_OCC] = q_reg.chg_occ;  // see [RULE12]
                    s_next.rsp.prdata[ST_RUN] = !edit_ok;
                    s_next.rsp.prdata[ST_TRIG] = q_reg.trig;
                    s_next.rsp.prdata[ST_DONE] = q_reg.phase == PH_DONE;
                    s_next.rsp.prdata[ST_HALT] = q_reg.halted;
                    s_next.rsp.prdata[ST_NTERM +: TW] = q_reg.nterms;
                end
                ADDR_OCC: s_next.rsp.prdata = q_reg.chg_occ ? '0 : 32'(q_reg.occ_left);  // see [RULE11] [RULE12]
                ADDR_COUNT: begin
                    s_next.rsp.prdata[AW:0] = captured;  // see [RULE13]
                    s_next.rsp.prdata[CNT_OLDEST +: AW+1] = (AW+1)'(0) - kept;  // see [RULE22]
                end
                ADDR_RDIDX: s_next.rsp.prdata = 32'(q_reg.rdidx);
                ADDR_RDDATA: s_next.rsp.prdata = q_reg.mem[AW'(q_reg.trig_addr + q_reg.rdidx)];  // see [RULE22]
                default: begin
                    if (addr >= ADDR_TERM0 && addr <= ADDR_TERM3) begin
                        s_next.rsp.prdata = 32'(q_reg.terms[addr[3:2]]);
                    end else begin
                        s_next.rsp.pslverr = 1'b1;
                    end
                end
            endcase
        end

        // Motion seen by status reads
        s_next.chg_term = !s_next.halted && (s_next.term != q_reg.term);  // see [RULE10]
        s_next.chg_occ = !s_next.halted && (s_next.occ_left != q_reg.occ_left);  // see [RULE12]
        // Done level kept in a flop of its own
        s_next.done = s_next.phase == PH_DONE;
    end

    // ****************************************
    // Registers
    // ****************************************
    // State register with synchronous reset
    always_ff @(posedge mclk) begin
        if (srst) begin
            q_reg <= '0;
            q_reg.mode <= PLACE_START;  // see [RULE14]
            q_reg.nterms <= TERM_ONE;
            q_reg.terms <= {NTERM{TERM_DEFAULT}};
            q_reg.term <= TERM_ONE;
            q_reg.phase <= PH_IDLE;
        end else begin
            q_reg <= s_next;
        end
    end

    // Outputs straight from flops
    assign apb_rsp = q_reg.rsp;
    assign triggered = q_reg.trig;
    assign trace_done = q_reg.done;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    chk_trig_last_term: assert property ($rose(q_reg.trig) |-> $past(q_reg.term) == $past(q_reg.nterms)) // see [RULE1]
        else $error("trigger not from last term");
    chk_step_next_term: assert property ((q_reg.term > $past(q_reg.term)) |-> q_reg.term == $past(q_reg.term) + TERM_ONE) // see [RULE2]
        else $error("primary branch skipped a term");
    chk_restart_to_one: assert property ((q_reg.term < $past(q_reg.term)) |-> q_reg.term == TERM_ONE) // see [RULE3]
        else $error("restart not to term one");
    chk_term_count: assert property (q_reg.nterms >= TERM_ONE && q_reg.nterms <= TW'(NTERM)) // see [RULE4]
        else $error("term count out of range");
    chk_trig_term_plus: assert property (q_reg.phase == PH_POST |-> q_reg.term == q_reg.nterms + TERM_ONE) // see [RULE8]
        else $error("term after trigger wrong");
    chk_halt_holds_term: assert property ((q_reg.halted && !commit) |=> q_reg.halted && $stable(q_reg.term)) // see [RULE9]
        else $error("halted term moved");
    chk_occ_step: assert property (($past(q_reg.phase) == PH_ARMED && $past(smp.valid) && !$past(smp.restart)
        && !$past(commit) && $stable(q_reg.term) && q_reg.occ_left != $past(q_reg.occ_left))
        |-> q_reg.occ_left == $past(q_reg.occ_left) - OCC_ONE) // see [RULE20]
        else $error("occurrence count stepped wrong");
    chk_start_full: assert property ((q_reg.phase == PH_DONE && !q_reg.halted && q_reg.pre_keep == '0)
        |-> q_reg.post_cnt == (AW+1)'(PRE_END)) // see [RULE15]
        else $error("start placement did not fill memory");
    chk_ready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready)
        else $error("pready longer than one cycle");
endmodule

// >>> rtl/tsq_pkg.sv
package tsq_pkg;
    // ****************************************
    // Sizes
    // ****************************************
    localparam int NTERM = 4;            // Most sequence terms
    localparam int DEPTH = 512;          // Trace memory states
    localparam int AW = 9;               // Trace memory index width
    localparam int DW = 32;              // Stored state width
    localparam int OCW = 16;             // Occurrence count width
    localparam int TW = 3;               // Term number width
    // ****************************************
    // Register byte offsets
    // ****************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_TPOS = 8'h04;
    localparam logic [7:0] ADDR_SEQCMD = 8'h08;
    localparam logic [7:0] ADDR_TERM0 = 8'h10;
    localparam logic [7:0] ADDR_TERM3 = 8'h1c;
    localparam logic [7:0] ADDR_STATUS = 8'h20;
    localparam logic [7:0] ADDR_OCC = 8'h24;
    localparam logic [7:0] ADDR_COUNT = 8'h28;
    localparam logic [7:0] ADDR_RDIDX = 8'h2c;
    localparam logic [7:0] ADDR_RDDATA = 8'h30;
    // ****************************************
    // Field positions and values
    // ****************************************
    localparam int CTRL_START = 0;       // Write 1 starts a trace
    localparam int CTRL_HALT = 1;        // Write 1 halts a trace
    localparam int CTRL_MODE = 2;        // Two bits, placement mode
    localparam int CTRL_AFTER = 4;       // Count is states after trigger
    localparam int TERM_ANY = 16;        // Primary matches any state
    localparam int CMD_POS = 2;          // Three bits, term position
    localparam int ST_UNK_TERM = 3;
    localparam int ST_UNK_OCC = 4;
    localparam int ST_RUN = 5;
    localparam int ST_TRIG = 6;
    localparam int ST_DONE = 7;
    localparam int ST_HALT = 8;
    localparam int ST_NTERM = 16;
    localparam int CNT_OLDEST = 16;
    localparam logic [AW-1:0] PRE_CENTRE = 9'h100;
    localparam logic [AW-1:0] PRE_END = 9'h1ff;
    localparam logic [OCW-1:0] OCC_ONE = 16'h0001;
    localparam logic [TW-1:0] TERM_ONE = 3'h1;
    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {PLACE_START, PLACE_CENTRE, PLACE_END, PLACE_COUNT} tsq_place_t;
    typedef enum logic [1:0] {CMD_NONE, CMD_INSERT, CMD_DELETE, CMD_RESET} tsq_cmd_t;
    typedef enum logic [1:0] {PH_IDLE, PH_ARMED, PH_POST, PH_DONE} tsq_phase_t;
    typedef struct packed {
        logic any;
        logic [OCW-1:0] occ;
    } tsq_term_t;
    localparam tsq_term_t TERM_DEFAULT = '{any: 1'b1, occ: OCC_ONE};
    typedef struct packed {
        logic valid;
        logic [NTERM-1:0] hit;
        logic restart;
        logic store;
        logic [DW-1:0] data;
    } tsq_sample_t;
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } tsq_apb_req_t;
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } tsq_apb_rsp_t;
endpackage

// >>> bench/tsq_bus_model.sv
// Observed processor bus: one sample per cycle while a burst runs
module tsq_bus_model import tsq_pkg::*; (
    input wire logic mclk,
    output tsq_sample_t smp
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Sample source
    // ****************************************
    logic [DW-1:0] cnt = '0; // Data of the next state, counts up
    initial smp = '0;
    // Burst of n states with fixed match, restart and store lines
    task automatic burst(input logic [NTERM-1:0] h, input logic rs, input logic st, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge mclk);
            smp <= '{valid: 1'b1, hit: h, restart: rs, store: st, data: cnt};
            cnt = cnt + 1;
        end
        @(posedge mclk);
        // Idle bus: data flips so no stale value looks valid
        smp <= '{valid: 1'b0, hit: '0, restart: 1'b0, store: 1'b0, data: ~smp.data};
    endtask
endmodule

// >>> bench/test_tsq_top.sv
module test_tsq_top import tsq_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0; // Bus clock
    logic srst = 1'b1; // Held for the first cycles
    tsq_apb_req_t req = '0; // Register bus request
    tsq_apb_rsp_t rsp; // Register bus answer
    tsq_sample_t smp; // States from the bus model
    logic triggered;
    logic trace_done;
    int n_fail = 0;
    int check_count = 0;
    logic [31:0] tg; // Data of the trigger state
    initial forever #12.5 mclk = ~mclk;
    tsq_top uut (.mclk(mclk), .srst(srst), .apb_req(req), .apb_rsp(rsp), .smp(smp),
        .triggered(triggered), .trace_done(trace_done));
    tsq_bus_model bm (.mclk(mclk), .smp(smp));
    // ****************************************
    // Tasks
    // ****************************************
    // Compare one value, count it and report a mismatch
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask
    // Counts, verdict, end of run
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // One transfer: setup, access held until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
        output logic e);
        int k;
        @(posedge mclk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge mclk);
        req.penable <= 1'b1;
        for (k = 0; k < 16; k++) begin
            @(posedge mclk);
            if (rsp.pready === 1'b1) break;
        end
        r = rsp.prdata;
        e = rsp.pslverr;
        req <= '0;
        if (k == 16) begin
            chk(32'h0, 32'h1, "pready never came");
            summarize();
        end
    endtask
    // Write and check the error response
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic err);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        chk({31'h0, e}, {31'h0, err}, $sformatf("error on write to %h", a));
    endtask
    // Read and check the masked data
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r & m, exp, $sformatf("read at %h", a));
    endtask
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        repeat (4) @(posedge mclk);
        srst <= 1'b0;
        // Defaults, unmapped place, placement modes
        rd(ADDR_STATUS, 32'h0007_01ff, 32'h0001_0001);
        rd(ADDR_CTRL, 32'h0000_000c, 32'h0);
        wr(8'h3c, 32'h1, 1'b1);
        rd(8'h3c, 32'hffff_ffff, 32'h0);
        for (int m = 0; m < 4; m++) begin
            wr(ADDR_CTRL, 32'(m << CTRL_MODE), 1'b0);
            rd(ADDR_CTRL, 32'h0000_000c, 32'(m << CTRL_MODE));
        end
        wr(ADDR_CTRL, 32'h0, 1'b0);
        $display("test defaults done");
        // Insert, append, overflow, delete
        wr(ADDR_SEQCMD, 32'h09, 1'b0);
        rd(ADDR_TERM0 + 8'h4, 32'h0001_ffff, 32'h0001_0001);
        wr(ADDR_TERM0 + 8'h4, 32'h5, 1'b0);
        wr(ADDR_SEQCMD, 32'h09, 1'b0);
        rd(ADDR_TERM0 + 8'h8, 32'h0001_ffff, 32'h5);
        wr(ADDR_SEQCMD, 32'h11, 1'b0);
        wr(ADDR_SEQCMD, 32'h15, 1'b1);
        rd(ADDR_STATUS, 32'h0007_0000, 32'h0004_0000);
        wr(ADDR_SEQCMD, 32'h0a, 1'b0);
        rd(ADDR_TERM0 + 8'h4, 32'h0001_ffff, 32'h5);
        wr(ADDR_SEQCMD, 32'h0e, 1'b0);
        rd(ADDR_STATUS, 32'h0007_0000, 32'h0002_0000);
        $display("test edit done");
        // Two terms: counts, restart, trigger, start placement
        wr(ADDR_TERM0, 32'h2, 1'b0);
        wr(ADDR_TERM0 + 8'h4, 32'h1, 1'b0);
        wr(ADDR_CTRL, 32'h1, 1'b0);
        bm.burst(4'b0001, 1'b0, 1'b1, 1);
        rd(ADDR_OCC, 32'h0000_ffff, 32'h1);
        bm.burst(4'b0001, 1'b0, 1'b1, 1);
        rd(ADDR_STATUS, 32'h7, 32'h2);
        bm.burst(4'b0000, 1'b1, 1'b1, 1);
        rd(ADDR_STATUS, 32'h7, 32'h1);
        rd(ADDR_OCC, 32'h0000_ffff, 32'h2);
        bm.burst(4'b0001, 1'b0, 1'b1, 2);
        tg = bm.cnt;
        bm.burst(4'b0010, 1'b0, 1'b1, 1);
        rd(ADDR_STATUS, 32'h7, 32'h3);
        chk({31'h0, triggered}, 32'h1, "trigger output");
        bm.burst(4'b0000, 1'b0, 1'b1, 520);
        chk({31'h0, trace_done}, 32'h1, "done output");
        rd(ADDR_COUNT, 32'h03ff_03ff, 32'h0000_0200);
        wr(ADDR_RDIDX, 32'h0, 1'b0);
        rd(ADDR_RDDATA, 32'hffff_ffff, tg);
        wr(ADDR_RDIDX, 32'h0ff, 1'b0);
        rd(ADDR_RDDATA, 32'hffff_ffff, tg + 32'd255);
        $display("test trigger done");
        // Ten states before trigger, unqualified states skipped
        wr(ADDR_SEQCMD, 32'h3, 1'b0);
        wr(ADDR_TERM0, 32'h0, 1'b0);
        wr(ADDR_TPOS, 32'd10, 1'b0);
        wr(ADDR_CTRL, 32'h0000_000d, 1'b0);
        bm.burst(4'b0000, 1'b0, 1'b1, 20);
        bm.burst(4'b0000, 1'b0, 1'b0, 5);
        tg = bm.cnt;
        bm.burst(4'b0001, 1'b0, 1'b0, 1);
        bm.burst(4'b0000, 1'b0, 1'b1, 520);
        rd(ADDR_COUNT, 32'h03ff_03ff, 32'h03f6_0200);
        wr(ADDR_RDIDX, 32'h1f6, 1'b0);
        rd(ADDR_RDDATA, 32'hffff_ffff, tg - 32'd15);
        wr(ADDR_RDIDX, 32'h0, 1'b0);
        rd(ADDR_RDDATA, 32'hffff_ffff, tg);
        $display("test count placement done");
        // Halt in term two
        wr(ADDR_SEQCMD, 32'h09, 1'b0);
        wr(ADDR_CTRL, 32'h1, 1'b0);
        bm.burst(4'b0001, 1'b0, 1'b1, 1);
        wr(ADDR_CTRL, 32'h2, 1'b0);
        rd(ADDR_STATUS, 32'h1ff, 32'h182);
        chk({31'h0, trace_done}, 32'h1, "done after halt");
        $display("test halt done");
        // Count moving every cycle reads as unknown
        wr(ADDR_SEQCMD, 32'h3, 1'b0);
        wr(ADDR_TERM0, 32'h0000_0100, 1'b0);
        wr(ADDR_CTRL, 32'h1, 1'b0);
        fork
            bm.burst(4'b0001, 1'b0, 1'b1, 20);
            begin
                rd(ADDR_STATUS, 32'h10, 32'h10);
                rd(ADDR_OCC, 32'h0000_ffff, 32'h0);
            end
        join
        $display("test unknown count done");
        summarize();
    end
endmodule
